/* File: hdl/tcrs_pkg.sv */
// package: constants and types for the touch controller reset sequencer
package tcrs_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned NS_PER_MS = 1_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FAIL_PULSE_MS = 5;
  localparam int unsigned HOST_PULSE_MS = 16;
  localparam int unsigned BOUND_NORMAL_MS = 350;
  localparam int unsigned BOUND_HIGH_MS = 1000;
  localparam int unsigned FAIL_PULSE_CYC = FAIL_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned HOST_PULSE_CYC = HOST_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned BOUND_NORMAL_CYC = BOUND_NORMAL_MS * (CLK_HZ / 1000);
  localparam int unsigned BOUND_HIGH_CYC = BOUND_HIGH_MS * (CLK_HZ / 1000);
  localparam int unsigned LOAD_CYC_DEF = 64;
  localparam int unsigned INIT_CYC_DEF = 16;
  localparam int unsigned DIAG_CYC_DEF = 32;
  localparam int unsigned EFFECT_CYC_DEF = 1000;
  localparam int unsigned NUM_SENSORS = 10;
  // register byte offsets
  localparam logic [11:0] ADDR_HOST_MODE = 12'h000;
  localparam logic [11:0] ADDR_CONFIG = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_HOST_OUT = 12'h00C;
  // field positions
  localparam int unsigned SWRST_BIT = 0;
  localparam int unsigned SAVE_BIT = 1;
  localparam int unsigned NOISE_HIGH_BIT = 0;
  localparam int unsigned EFFECTS_EN_BIT = 1;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  typedef enum logic [6:0] {
    TCRS_IDLE = 7'h01,
    TCRS_LOAD = 7'h02,
    TCRS_INIT = 7'h04,
    TCRS_DIAG = 7'h08,
    TCRS_FAILP = 7'h10,
    TCRS_EFFECT = 7'h20,
    TCRS_OPER = 7'h40
  } tcrs_state_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } tcrs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tcrs_apb_rsp_t;
endpackage : tcrs_pkg

/* File: hdl/tcrs_sequencer.sv */
// module: reset sequencer with apb registers and pulse outputs
//
// Summary of operation
// - hw reset: reload both sets, init, diagnose
// - 5 ms pulse on failing sensor outputs
// - sequence done within 350/1000 ms bound
// - hw reset effects on good outputs, then operate
// - power-up: 16 ms high pulse on host output
// - pin reset gives no host output pulse
// - writing software reset bit in operate resets
// - sw reset reloads, self-clears bit, initialises
// - sw reset skips diagnostics and effects
// - any reset drives host output low, except while the power-up pulse runs
// - save-to-flash completion causes software reset
module tcrs_sequencer #(
  parameter int unsigned SENSORS = 10,
  parameter int unsigned LOAD_CYC = 64,
  parameter int unsigned INIT_CYC = 16,
  parameter int unsigned DIAG_CYC = 32,
  parameter int unsigned EFFECT_CYC = 1000,
  parameter int unsigned FAIL_CYC = 500000,
  parameter int unsigned HOSTP_CYC = 1600000,
  parameter int unsigned BOUND_N_CYC = 35000000,
  parameter int unsigned BOUND_H_CYC = 100000000
) (
  input wire logic clk,
  input wire logic srst,
  input wire tcrs_pkg::tcrs_apb_req_t apbReq,
  output tcrs_pkg::tcrs_apb_rsp_t apbRsp,
  input wire logic external_reset_pin,
  input wire logic [SENSORS-1:0] touch_sensor_input,
  output logic [SENSORS-1:0] indicator_output,
  output logic host_output_one_pin,
  output logic [SENSORS-1:0] ramLoadOut,
  output logic blocksInitOut,
  output logic operatingOut
);
  import tcrs_pkg::*;

  // status word holds the fail mask from bit 8 upwards
  if (SENSORS < 1 || SENSORS > 24 || LOAD_CYC < 1 || INIT_CYC < 1 ||
      DIAG_CYC < 1 || EFFECT_CYC < 1 || FAIL_CYC < 1 || HOSTP_CYC < 8 ||
      BOUND_N_CYC < 1 || BOUND_H_CYC < BOUND_N_CYC) begin : g_badParam
    $error("tcrs_sequencer: bad parameter");
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and reset pin edge
  logic [1:0] pinSync_reg;
  logic pinPrev_reg;
  logic [SENSORS-1:0] sensA_reg;
  logic [SENSORS-1:0] sensB_reg;
  logic pinReset;

  always_ff @(posedge clk) begin
    if (srst) begin
      pinSync_reg <= 2'h0;
      pinPrev_reg <= 1'b0;
      sensA_reg <= '0;
      sensB_reg <= '0;
    end else begin
      pinSync_reg <= {pinSync_reg[0], external_reset_pin};
      pinPrev_reg <= pinSync_reg[1];
      sensA_reg <= touch_sensor_input;
      sensB_reg <= sensA_reg;
    end
  end

  // high then low completes a pin reset
  assign pinReset = pinPrev_reg & ~pinSync_reg[1];

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0] hostMode_reg;
  logic [1:0] config_reg;
  logic [SENSORS-1:0] failMask_reg;
  logic hostLevel_reg;
  logic hostWrite;
  logic swReq;
  logic isOper;
  tcrs_state_t state_reg;
  tcrs_state_t state_next;
  logic wrAcc;
  logic rdAcc;
  logic addrOk;
  logic [31:0] rdData;

  assign isOper = (state_reg == TCRS_OPER);
  assign wrAcc = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign rdAcc = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
  assign addrOk = (apbReq.paddr == ADDR_HOST_MODE) ||
                  (apbReq.paddr == ADDR_CONFIG) ||
                  (apbReq.paddr == ADDR_STATUS) ||
                  (apbReq.paddr == ADDR_HOST_OUT);
  // sw reset bit or save-to-flash, only in operating mode
  assign swReq = wrAcc & isOper & (apbReq.paddr == ADDR_HOST_MODE) &
                 (apbReq.pwdata[SWRST_BIT] | apbReq.pwdata[SAVE_BIT]);
  assign hostWrite = wrAcc & (apbReq.paddr == ADDR_HOST_OUT);

  always_ff @(posedge clk) begin
    if (srst) begin
      hostMode_reg <= 2'h0;
    end else if (swReq) begin
      hostMode_reg <= apbReq.pwdata[1:0];
    end else if (state_reg == TCRS_LOAD) begin
      hostMode_reg <= 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      config_reg <= CONFIG_RESET[1:0];
    end else if (wrAcc && apbReq.paddr == ADDR_CONFIG) begin
      config_reg <= apbReq.pwdata[1:0];
    end
  end

  always_comb begin
    rdData = 32'h0000_0000;
    case (apbReq.paddr)
      ADDR_HOST_MODE: rdData[1:0] = hostMode_reg;
      ADDR_CONFIG: rdData[1:0] = config_reg;
      ADDR_STATUS: begin
        rdData[6:0] = state_reg;
        rdData[8 +: SENSORS] = failMask_reg;
      end
      ADDR_HOST_OUT: rdData[0] = hostLevel_reg;
      default: rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready <= apbReq.psel & ~apbReq.penable;
      apbRsp.pslverr <= apbReq.psel & ~apbReq.penable & ~addrOk;
      if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
        apbRsp.prdata <= rdData;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequence state machine
  logic hwPending_reg;
  logic [31:0] cnt_reg;
  logic [31:0] bound_reg;
  logic cntDone;
  logic restart;

  assign restart = pinReset | swReq;
  assign cntDone = (cnt_reg == 32'h0000_0000);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TCRS_IDLE: state_next = TCRS_LOAD;
      TCRS_LOAD: if (cntDone) state_next = TCRS_INIT;
      TCRS_INIT: if (cntDone) begin
        state_next = hwPending_reg ? TCRS_DIAG : TCRS_OPER;
      end
      TCRS_DIAG: if (cntDone) state_next = TCRS_FAILP;
      TCRS_FAILP: if (cntDone) begin
        state_next = config_reg[EFFECTS_EN_BIT] ? TCRS_EFFECT : TCRS_OPER;
      end
      TCRS_EFFECT: if (cntDone) state_next = TCRS_OPER;
      TCRS_OPER: state_next = TCRS_OPER;
      default: state_next = TCRS_IDLE;
    endcase
    if (restart) begin
      state_next = TCRS_LOAD;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= TCRS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 32'h0000_0000;
    end else if (state_next != state_reg || restart) begin
      case (state_next)
        TCRS_LOAD: cnt_reg <= 32'(LOAD_CYC - 1);
        TCRS_INIT: cnt_reg <= 32'(INIT_CYC - 1);
        TCRS_DIAG: cnt_reg <= 32'(DIAG_CYC - 1);
        TCRS_FAILP: cnt_reg <= 32'(FAIL_CYC - 1);
        TCRS_EFFECT: cnt_reg <= 32'(EFFECT_CYC - 1);
        default: cnt_reg <= 32'h0000_0000;
      endcase
    end else if (!cntDone) begin
      cnt_reg <= cnt_reg - 32'h0000_0001;
    end
  end

  // hardware origin: power-up or pin; software reset or reaching operate clears it
  always_ff @(posedge clk) begin
    if (srst) begin
      hwPending_reg <= 1'b1;
    end else if (pinReset) begin
      hwPending_reg <= 1'b1;
    end else if (swReq) begin
      hwPending_reg <= 1'b0;
    end else if (state_reg == TCRS_OPER) begin
      hwPending_reg <= 1'b0;
    end
  end

  // deadline watch for the initialisation window
  always_ff @(posedge clk) begin
    if (srst) begin
      bound_reg <= 32'h0000_0000;
    end else if (restart || state_reg == TCRS_IDLE) begin
      bound_reg <= config_reg[NOISE_HIGH_BIT] ? 32'(BOUND_H_CYC)
                                              : 32'(BOUND_N_CYC);
    end else if (bound_reg != 32'h0000_0000) begin
      bound_reg <= bound_reg - 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // diagnostics result and pin outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      failMask_reg <= '0;
    end else if (state_reg == TCRS_DIAG && cntDone) begin
      failMask_reg <= sensB_reg;
    end else if (restart) begin
      failMask_reg <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      indicator_output <= '0;
    end else if (state_next == TCRS_FAILP) begin
      indicator_output <= failMask_reg | (state_reg == TCRS_DIAG ?
                          sensB_reg : '0);
    end else if (state_next == TCRS_EFFECT) begin
      indicator_output <= ~failMask_reg;
    end else begin
      indicator_output <= '0;
    end
  end

  logic [31:0] hostCnt_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      hostCnt_reg <= 32'(HOSTP_CYC);
    end else if (hostCnt_reg != 32'h0000_0000) begin
      hostCnt_reg <= hostCnt_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hostLevel_reg <= 1'b0;
    end else if (restart) begin
      hostLevel_reg <= 1'b0;
    end else if (hostWrite) begin
      hostLevel_reg <= apbReq.pwdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      host_output_one_pin <= 1'b0;
    end else begin
      host_output_one_pin <= (hostCnt_reg != 32'h0000_0000) |
                             (hostLevel_reg & ~restart);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ramLoadOut <= '0;
      blocksInitOut <= 1'b0;
      operatingOut <= 1'b0;
    end else begin
      ramLoadOut <= {SENSORS{state_next == TCRS_LOAD}};
      blocksInitOut <= (state_next == TCRS_INIT);
      operatingOut <= (state_next == TCRS_OPER);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_hwInitDone;
    state_reg == TCRS_INIT && cntDone && hwPending_reg;
  endsequence

  a_hw_goes_diag: assert property (@(posedge clk) disable iff (srst)
    (s_hwInitDone and !restart) |=> state_reg == TCRS_DIAG)
    else $error("hw reset skipped diagnostics");

  a_sw_no_diag: assert property (@(posedge clk) disable iff (srst)
    swReq |-> ##1 (state_reg != TCRS_DIAG && state_reg != TCRS_EFFECT)
    [*2])
    else $error("sw reset ran diagnostics");

  a_restart_load: assert property (@(posedge clk) disable iff (srst)
    restart |=> state_reg == TCRS_LOAD && cnt_reg == 32'(LOAD_CYC - 1))
    else $error("restart not at reload");

  a_swbit_clear: assert property (@(posedge clk) disable iff (srst)
    swReq |-> ##2 hostMode_reg == 2'h0)
    else $error("software reset bit not cleared");

  a_fail_pulse: assert property (@(posedge clk) disable iff (srst)
    $rose(state_reg == TCRS_FAILP) |-> cnt_reg == 32'(FAIL_CYC - 1))
    else $error("failure pulse length wrong");

  a_host_low_reset: assert property (@(posedge clk) disable iff (srst)
    restart && hostCnt_reg == 32'h0000_0000 |=> !host_output_one_pin)
    else $error("host output not low on reset");

  a_pin_no_pulse: assert property (@(posedge clk) disable iff (srst)
    pinReset && hostCnt_reg == 32'h0000_0000 |-> ##1 !host_output_one_pin
    ##1 !hostLevel_reg)
    else $error("pin reset pulsed host output");

  a_bound_met: assert property (@(posedge clk) disable iff (srst)
    bound_reg == 32'h0000_0001 && !restart |->
    state_reg inside {TCRS_DIAG, TCRS_FAILP, TCRS_EFFECT, TCRS_OPER})
    else $error("initialisation overran bound");

  a_oper_only_sw: assert property (@(posedge clk) disable iff (srst)
    wrAcc && apbReq.paddr == ADDR_HOST_MODE && !isOper |=>
    hostMode_reg == 2'h0)
    else $error("software reset outside operating mode");

  a_save_clears: assert property (@(posedge clk) disable iff (srst)
    swReq && apbReq.pwdata[SAVE_BIT] |=> !hostLevel_reg)
    else $error("save did not clear host output level");

  a_effects_after: assert property (@(posedge clk) disable iff (srst)
    state_reg == TCRS_EFFECT |-> indicator_output == ~failMask_reg ||
    state_next != TCRS_EFFECT)
    else $error("effects on failing output");

  a_power_pulse: assert property (@(posedge clk)
    $fell(srst) |=> host_output_one_pin [*8])
    else $error("power-up host pulse missing");

endmodule : tcrs_sequencer

/* File: bench/tcrs_host_model.sv */
// partner: apb host that configures the sequencer
module tcrs_host_model (
  input wire logic clk,
  output tcrs_pkg::tcrs_apb_req_t apbReq,
  input wire tcrs_pkg::tcrs_apb_rsp_t apbRsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import tcrs_pkg::*;

  bit tmo = 1'b0;

  initial apbReq = '0;

  ////////////////////////////////////////////////////////////////////////////
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    int n;
    n = 0;
    rd = 32'hFFFF_FFFF;
    err = 1'b1;
    @(posedge clk);
    apbReq <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr,
                pwdata: wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 16);
    tmo = (apbRsp.pready !== 1'b1);
    if (apbRsp.pready === 1'b1) begin
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
    end
    apbReq <= '0;
  endtask : xfer
endmodule : tcrs_host_model

/* File: bench/tb_touch_controller_reset_sequencer.sv */
// testbench: reset sources, pulses, bounds and registers of the sequencer
module tb_touch_controller_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import tcrs_pkg::*;

  localparam int unsigned LD = 8;
  localparam int unsigned FL = 20;
  localparam int unsigned HP = 40;
  localparam int unsigned EF = 10;
  localparam int unsigned BN = 2000;
  localparam int unsigned BH = 4000;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic extPin = 1'b0;
  logic clr = 1'b0;
  logic [NUM_SENSORS-1:0] touch = '0;
  logic [NUM_SENSORS-1:0] ind;
  logic [NUM_SENSORS-1:0] ramLoad;
  logic hostPin;
  logic initOut;
  logic oper;
  logic rerr;
  logic [31:0] rdat;
  logic [31:0] seed = 32'h126262A6;
  tcrs_apb_req_t apbReq;
  tcrs_apb_rsp_t apbRsp;
  int failures = 0;
  int compares = 0;
  int hostHi, failC, effC, loadC, initC;

  always #5 clk = ~clk;

  tcrs_sequencer #(.SENSORS(NUM_SENSORS), .LOAD_CYC(LD), .INIT_CYC(4),
    .DIAG_CYC(4), .EFFECT_CYC(EF), .FAIL_CYC(FL), .HOSTP_CYC(HP),
    .BOUND_N_CYC(BN), .BOUND_H_CYC(BH)) tcrs_sequencer_i (
    .clk(clk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
    .external_reset_pin(extPin), .touch_sensor_input(touch),
    .indicator_output(ind), .host_output_one_pin(hostPin),
    .ramLoadOut(ramLoad), .blocksInitOut(initOut), .operatingOut(oper));

  tcrs_host_model tcrs_host_model_i (
    .clk(clk), .apbReq(apbReq), .apbRsp(apbRsp));

  ////////////////////////////////////////////////////////////////////////////
  // monitor: cycle counts of each output phase
  always @(posedge clk) begin
    if (srst || clr) begin
      hostHi <= 0;
      failC <= 0;
      effC <= 0;
      loadC <= 0;
      initC <= 0;
    end else begin
      hostHi <= hostHi + int'(hostPin);
      failC <= failC + int'(ind == touch && ind != '0);
      effC <= effC + int'(ind == ~touch && ind != '0);
      loadC <= loadC + int'(ramLoad == '1);
      initC <= initC + int'(initOut);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // expectations and helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic int unsigned exp_fail(input bit hw);
    return hw ? FL : 0;
  endfunction : exp_fail

  function automatic int unsigned exp_eff(input bit hw, input bit en);
    return (hw && en) ? EF : 0;
  endfunction : exp_eff

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic bus_ok;
    if (tcrs_host_model_i.tmo) begin
      failures++;
      end_of_test();
    end
  endtask : bus_ok

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    tcrs_host_model_i.xfer(1'b1, a, d, rdat, rerr);
    bus_ok();
  endtask : wr

  task automatic rd(input logic [11:0] a);
    tcrs_host_model_i.xfer(1'b0, a, 32'h0, rdat, rerr);
    bus_ok();
  endtask : rd

  task automatic clr_mon;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : clr_mon

  task automatic new_mask;
    seed = xs(seed);
    @(posedge clk);
    touch <= (seed[9:0] & 10'h155) | 10'h001;
    repeat (4) @(posedge clk);
  endtask : new_mask

  task automatic wait_oper(input int unsigned bound);
    int unsigned n;
    n = 0;
    while (oper === 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    while (oper !== 1'b1 && n < bound) begin
      @(posedge clk);
      n++;
    end
    check(n < bound, 32'h1);
    if (n >= bound) begin
      end_of_test();
    end
  endtask : wait_oper

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = xs(seed);
    touch <= (seed[9:0] & 10'h155) | 10'h001;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    wait_oper(BN);
    repeat (HP) @(posedge clk);
    check(hostHi, HP);
    check(failC, exp_fail(1));
    check(effC, exp_eff(1, 0));
    check(loadC != 0 && initC != 0, 32'h1);
    rd(ADDR_CONFIG);
    check(rdat, CONFIG_RESET);
    rd({seed[7:0] | 8'h01, 4'h0});
    check(rerr, 32'h1);
    check(rdat, 32'h0);
    wr(ADDR_HOST_OUT, 32'h1);
    repeat (2) @(posedge clk);
    check(hostPin, 32'h1);
    wr(ADDR_CONFIG, 32'h3);
    clr_mon();
    wr(ADDR_HOST_MODE, 32'h1 << SAVE_BIT);
    wait_oper(BH);
    check(loadC != 0, 32'h1);
    check(failC, exp_fail(0));
    check(effC, exp_eff(0, 1));
    check(hostPin, 32'h0);
    rd(ADDR_CONFIG);
    check(rdat, 32'h3);
    new_mask();
    clr_mon();
    @(posedge clk);
    extPin <= 1'b1;
    repeat (3) @(posedge clk);
    extPin <= 1'b0;
    repeat (6) @(posedge clk);
    wr(ADDR_HOST_MODE, 32'h1 << SWRST_BIT);
    rd(ADDR_HOST_MODE);
    check(rdat, 32'h0);
    wait_oper(BH);
    repeat (HP) @(posedge clk);
    check(hostHi, 32'h0);
    check(failC, exp_fail(1));
    check(effC, exp_eff(1, 1));
    check(loadC != 0 && initC != 0, 32'h1);
    rd(ADDR_STATUS);
    check(rdat, {14'h0000, touch, 1'b0, TCRS_OPER});
    wr(ADDR_HOST_OUT, 32'h1);
    clr_mon();
    wr(ADDR_HOST_MODE, 32'h1 << SWRST_BIT);
    repeat (2) @(posedge clk);
    check(oper, 32'h0);
    wait_oper(BH);
    rd(ADDR_HOST_MODE);
    check(rdat, 32'h0);
    check(loadC != 0 && initC != 0, 32'h1);
    check(failC + effC, 32'h0);
    check(hostPin, 32'h0);
    clr_mon();
    @(posedge clk);
    extPin <= 1'b1;
    wr(ADDR_HOST_MODE, 32'h1 << SWRST_BIT);
    extPin <= 1'b0;
    wait_oper(BH);
    check(loadC > LD, 32'h1);
    check(failC, exp_fail(1));
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : tb_touch_controller_reset_sequencer
